// file: core/ebs_pkg.sv
package ebs_pkg;
  // Oscillator periods per machine cycle and per strobe slot
  localparam int unsigned OSC_PER_MCYCLE = 12;
  localparam int unsigned OSC_PER_ALE = 6;
  localparam logic [3:0] STATE_LAST = 4'hb;
  // Strobe phases inside a machine cycle (oscillator periods)
  localparam logic [3:0] ALE_PH_A = 4'h0;
  localparam logic [3:0] ALE_PH_B = 4'h6;
  localparam logic [3:0] ALE_LEN = 4'h2;
  localparam logic [3:0] RD_PH_A = 4'h3;
  localparam logic [3:0] RD_PH_B = 4'h9;
  localparam logic [3:0] RD_LEN = 4'h3;
  localparam logic [1:0] RST_MCYCLES = 2'h3;
  localparam logic [2:0] SER_DRAIN_MCYCLES = 3'h4;
  localparam logic [15:0] EXT_FETCH_TOP = 16'h0fff;
  localparam logic [7:0] PORT_RESET = 8'hff;
  typedef enum logic [1:0] {EBS_RUN, EBS_IDLE, EBS_RESET} ebs_mode_type;
endpackage

// file: core/ebs_tmg_if.sv
`timescale 1ns/1ps
interface ebs_tmg_if;
  logic osc_en;
  logic [3:0] state;
  logic mc_end;
  modport src (output osc_en, output state, output mc_end);
  modport snk (input osc_en, input state, input mc_end);
endinterface

// file: core/ebs_timing.sv
`timescale 1ns/1ps
module ebs_timing
  import ebs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  ebs_tmg_if.src tmg
);
  logic div_reg;
  logic [3:0] state_reg;

  // Divide-by-two: duty cycle of the incoming clock has no effect
  // Cleared with the state count so a machine cycle always ends on phase two
  always_ff @(posedge clk) begin
    if (rst || hold) div_reg <= 1'b0;
    else div_reg <= ~div_reg;
  end

  // One state per oscillator period, twelve to a machine cycle
  always_ff @(posedge clk) begin
    if (rst || hold) state_reg <= 4'h0;
    else state_reg <= (state_reg == STATE_LAST) ? 4'h0 : state_reg + 4'h1;
  end

  assign tmg.osc_en = div_reg;
  assign tmg.state = state_reg;
  assign tmg.mc_end = div_reg && (state_reg == STATE_LAST);

  property p_div;
    @(posedge clk) disable iff (rst) div_reg |=> !div_reg;
  endproperty
  a_div: assert property (p_div) else $error("divider not toggling");
endmodule // ebs_timing

// file: core/ebs_bus.sv
`timescale 1ns/1ps
// Function
// - Reset after three machine cycles low
// - Serial may transmit until reset is entered, three cycles after pin low
// - Address strobe at oscillator over six
// - One address strobe skipped per data access
// - Address strobe high during reset
// - Two read strobes skipped per data access
// - Port 4 takes low address in verify
// - Port 5 is low address/data bus
// - Port 6 drives high address byte
// - Alternate read strobe used when selected
// - Written ones weakly pull port pins high
// - Internal clock via divide-by-two
// - Idle halts CPU and DMA and parks the strobes high
// - Idle entered by software, state kept
// - Interrupt or reset leaves idle
module ebs_bus
  import ebs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic RESET_N_PIN,
  input wire logic EXTERNAL_FETCH_SELECT_N,
  input wire logic ALTERNATE_BUS_SELECT,
  input wire logic VERIFY_MODE,
  input wire logic FETCH_REQ,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic DATA_ACCESS,
  input wire logic IDLE_REQ,
  input wire logic IRQ_PENDING,
  input wire logic SER_TX_ACTIVE,
  input wire logic [7:0] P0_LATCH,
  input wire logic [7:0] P2_LATCH,
  input wire logic [7:0] P4_LATCH,
  input wire logic [7:0] P5_LATCH,
  input wire logic [7:0] P6_LATCH,
  input wire logic [7:0] P4_IN,
  output logic ADDRESS_LATCH_STROBE,
  output logic PROGRAM_READ_STROBE_N,
  output logic ALTERNATE_PROGRAM_READ_STROBE_N,
  output logic [7:0] P0_OUT,
  output logic [7:0] P0_OE_N,
  output logic [7:0] P2_OUT,
  output logic [7:0] P2_STRONG,
  output logic [7:0] P4_OUT,
  output logic [7:0] P4_OE_N,
  output logic [7:0] P5_OUT,
  output logic [7:0] P5_OE_N,
  output logic [7:0] P5_STRONG,
  output logic [7:0] P6_OUT,
  output logic [7:0] P6_STRONG,
  output logic [7:0] VERIFY_ADDR_LO,
  output logic CPU_RUN,
  output logic DMA_RUN,
  output logic SER_TX_ENABLE,
  output logic IN_RESET
);
  ebs_tmg_if tmg ();
  ebs_mode_type mode_reg;
  logic [2:0] rsync_reg;
  logic [1:0] rcnt_reg;
  logic [2:0] drain_reg;
  logic skip_ale_reg, skip_rd_reg;
  logic ale_reg, rd_reg, ard_reg;
  logic ext_fetch;
  logic [7:0] p0_out_reg, p0_oe_n_reg, p2_out_reg, p2_str_reg;
  logic [7:0] p5_out_reg, p5_oe_n_reg, p5_str_reg, p6_out_reg, p6_str_reg;
  logic [7:0] vaddr_reg;
  logic in_reset;

  function automatic logic in_win(input logic [3:0] st, input logic [3:0] ph,
                                  input logic [3:0] len);
    return (st >= ph) && (st < ph + len);
  endfunction

  ebs_timing u_timing (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .hold(in_reset),
    .tmg(tmg)
  );

  assign in_reset = (mode_reg == EBS_RESET);

  // Three flops; level counts only when second and third agree
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) rsync_reg <= 3'h7;
    else rsync_reg <= {rsync_reg[1:0], RESET_N_PIN};
  end

  // Low across three machine-cycle ends before reset takes effect
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) rcnt_reg <= 2'h0;
    else if (rsync_reg[1] || rsync_reg[2]) rcnt_reg <= 2'h0;
    else if (tmg.mc_end && rcnt_reg != RST_MCYCLES) rcnt_reg <= rcnt_reg + 2'h1;
  end

  // Mode: idle only on software request, left by interrupt or reset
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) mode_reg <= EBS_RESET;
    else begin
      case (mode_reg)
        EBS_RUN: begin
          if (rcnt_reg == RST_MCYCLES) mode_reg <= EBS_RESET;
          else if (IDLE_REQ) mode_reg <= EBS_IDLE;
        end
        EBS_IDLE: begin
          if (rcnt_reg == RST_MCYCLES) mode_reg <= EBS_RESET;
          else if (IRQ_PENDING) mode_reg <= EBS_RUN;
        end
        default: begin
          if (rsync_reg[1] && rsync_reg[2]) mode_reg <= EBS_RUN;
        end
      endcase
    end
  end

  // Serial output may drain only until reset is entered, three machine cycles after reset pin drop
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) drain_reg <= 3'h0;
    else if (rsync_reg[1] || rsync_reg[2]) drain_reg <= 3'h0;
    else if (tmg.mc_end && drain_reg != SER_DRAIN_MCYCLES) drain_reg <= drain_reg + 3'h1;
  end
  assign SER_TX_ENABLE = SER_TX_ACTIVE && !in_reset && (drain_reg != SER_DRAIN_MCYCLES);

  // Idle stops CPU and DMA and parks the strobes high; other state is not touched
  assign CPU_RUN = (mode_reg == EBS_RUN);
  assign DMA_RUN = (mode_reg == EBS_RUN);
  assign IN_RESET = in_reset;

  assign ext_fetch = !EXTERNAL_FETCH_SELECT_N || (FETCH_ADDR > EXT_FETCH_TOP);

  // A data access latched at machine-cycle start blanks one address strobe
  // and both read strobes of that cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || in_reset) begin
      skip_ale_reg <= 1'b0;
      skip_rd_reg <= 1'b0;
    end else if (tmg.mc_end) begin
      skip_ale_reg <= DATA_ACCESS;
      skip_rd_reg <= DATA_ACCESS;
    end
  end

  // Strobes; idle parks them high
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || in_reset) begin
      ale_reg <= 1'b1;
      rd_reg <= 1'b1;
      ard_reg <= 1'b1;
    end else if (mode_reg == EBS_IDLE) begin
      ale_reg <= 1'b1;
      rd_reg <= 1'b1;
      ard_reg <= 1'b1;
    end else begin
      ale_reg <= in_win(tmg.state, ALE_PH_A, ALE_LEN) ||
                 (in_win(tmg.state, ALE_PH_B, ALE_LEN) && !skip_ale_reg);
      rd_reg <= !(FETCH_REQ && ext_fetch && !ALTERNATE_BUS_SELECT && !skip_rd_reg &&
                  (in_win(tmg.state, RD_PH_A, RD_LEN) ||
                   in_win(tmg.state, RD_PH_B, RD_LEN)));
      ard_reg <= !(FETCH_REQ && ext_fetch && ALTERNATE_BUS_SELECT && !skip_rd_reg &&
                   (in_win(tmg.state, RD_PH_A, RD_LEN) ||
                    in_win(tmg.state, RD_PH_B, RD_LEN)));
    end
  end

  // Port drive: fetch bus on P0/P2 or P5/P6 per alternate select
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || in_reset) begin
      p0_out_reg <= PORT_RESET;
      p0_oe_n_reg <= PORT_RESET;
      p2_out_reg <= PORT_RESET;
      p2_str_reg <= 8'h00;
      p5_out_reg <= PORT_RESET;
      p5_oe_n_reg <= PORT_RESET;
      p5_str_reg <= 8'h00;
      p6_out_reg <= PORT_RESET;
      p6_str_reg <= 8'h00;
    end else if (FETCH_REQ && ext_fetch && ALTERNATE_BUS_SELECT) begin
      p5_out_reg <= FETCH_ADDR[7:0];
      p5_oe_n_reg <= ale_reg ? 8'h00 : PORT_RESET;
      p5_str_reg <= PORT_RESET;
      p6_out_reg <= FETCH_ADDR[15:8];
      p6_str_reg <= PORT_RESET;
      p0_out_reg <= P0_LATCH;
      p0_oe_n_reg <= P0_LATCH;
      p2_out_reg <= P2_LATCH;
      p2_str_reg <= 8'h00;
    end else if (FETCH_REQ && ext_fetch) begin
      p0_out_reg <= FETCH_ADDR[7:0];
      p0_oe_n_reg <= ale_reg ? 8'h00 : PORT_RESET;
      p2_out_reg <= FETCH_ADDR[15:8];
      p2_str_reg <= PORT_RESET;
      p5_out_reg <= P5_LATCH;
      p5_oe_n_reg <= P5_LATCH;
      p5_str_reg <= 8'h00;
      p6_out_reg <= P6_LATCH;
      p6_str_reg <= 8'h00;
    end else begin
      // Written ones stay weak so the pin can be read back
      p0_out_reg <= P0_LATCH;
      p0_oe_n_reg <= P0_LATCH;
      p2_out_reg <= P2_LATCH;
      p2_str_reg <= 8'h00;
      p5_out_reg <= P5_LATCH;
      p5_oe_n_reg <= P5_LATCH;
      p5_str_reg <= 8'h00;
      p6_out_reg <= P6_LATCH;
      p6_str_reg <= 8'h00;
    end
  end

  // Verification: low address byte arrives on Port 4
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) vaddr_reg <= 8'h00;
    else if (VERIFY_MODE) vaddr_reg <= P4_IN;
  end

  assign ADDRESS_LATCH_STROBE = ale_reg;
  assign PROGRAM_READ_STROBE_N = rd_reg;
  assign ALTERNATE_PROGRAM_READ_STROBE_N = ard_reg;
  assign P0_OUT = p0_out_reg;
  assign P0_OE_N = p0_oe_n_reg;
  assign P2_OUT = p2_out_reg;
  assign P2_STRONG = p2_str_reg;
  // Port 4 released in verify so the address can be driven in
  assign P4_OUT = P4_LATCH;
  assign P4_OE_N = VERIFY_MODE ? PORT_RESET : P4_LATCH;
  assign P5_OUT = p5_out_reg;
  assign P5_OE_N = p5_oe_n_reg;
  assign P5_STRONG = p5_str_reg;
  assign P6_OUT = p6_out_reg;
  assign P6_STRONG = p6_str_reg;
  assign VERIFY_ADDR_LO = vaddr_reg;

  sequence s_rst_low3;
    rcnt_reg == RST_MCYCLES;
  endsequence
  property p_rst_entry;
    @(posedge CORE_CLK) disable iff (SYS_RST) s_rst_low3 ##0 (mode_reg != EBS_RESET) |=>
      in_reset;
  endproperty
  a_rst_entry: assert property (p_rst_entry) else $error("reset not entered");
  property p_ale_rst;
    @(posedge CORE_CLK) disable iff (SYS_RST) in_reset [*2] |-> ale_reg;
  endproperty
  a_ale_rst: assert property (p_ale_rst) else $error("strobe low in reset");
  property p_rd_rst;
    @(posedge CORE_CLK) disable iff (SYS_RST) in_reset [*2] |-> rd_reg && ard_reg;
  endproperty
  a_rd_rst: assert property (p_rd_rst) else $error("read strobe in reset");
  // Idle or reset may park the strobe mid-period; such attempts are dropped
  property p_ale_rise;
    @(posedge CORE_CLK) disable iff (SYS_RST || mode_reg != EBS_RUN)
      $rose(ale_reg) && !skip_ale_reg |-> ##6 $rose(ale_reg);
  endproperty
  a_ale_rise: assert property (p_ale_rise) else $error("strobe period wrong");
  property p_skip_rd;
    @(posedge CORE_CLK) disable iff (SYS_RST) skip_rd_reg [*2] |-> rd_reg && ard_reg;
  endproperty
  a_skip_rd: assert property (p_skip_rd) else $error("read strobe not skipped");
  property p_one_rd;
    @(posedge CORE_CLK) disable iff (SYS_RST) !(rd_reg == 1'b0 && ard_reg == 1'b0);
  endproperty
  a_one_rd: assert property (p_one_rd) else $error("both read strobes active");
  property p_idle_stop;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (mode_reg == EBS_RUN) && IDLE_REQ && rcnt_reg != RST_MCYCLES |=> !CPU_RUN && !DMA_RUN;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle did not halt");
  property p_idle_wake;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (mode_reg == EBS_IDLE) && IRQ_PENDING && rcnt_reg != RST_MCYCLES |=> CPU_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
  property p_drain;
    @(posedge CORE_CLK) disable iff (SYS_RST) s_rst_low3 |=> !SER_TX_ENABLE;
  endproperty
  a_drain: assert property (p_drain) else $error("serial still sending");
  property p_mcycle;
    @(posedge CORE_CLK) disable iff (SYS_RST || in_reset)
      tmg.mc_end |-> ##12 (tmg.mc_end && tmg.osc_en);
  endproperty
  a_mcycle: assert property (p_mcycle) else $error("machine cycle length wrong");
  property p_skip_ale;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (mode_reg == EBS_RUN) && skip_ale_reg && (tmg.state == ALE_PH_B) |=> !ale_reg;
  endproperty
  a_skip_ale: assert property (p_skip_ale) else $error("strobe not skipped");
  property p_alt_strong;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      FETCH_REQ && ext_fetch && ALTERNATE_BUS_SELECT && !in_reset |=>
      (P5_STRONG == 8'hff) && (P6_STRONG == 8'hff);
  endproperty
  a_alt_strong: assert property (p_alt_strong) else $error("weak fetch port");
  property p_idle_park;
    @(posedge CORE_CLK) disable iff (SYS_RST) (mode_reg == EBS_IDLE) [*2] |-> ale_reg && rd_reg && ard_reg;
  endproperty
  a_idle_park: assert property (p_idle_park) else $error("strobe active in idle");
endmodule // ebs_bus

// file: verif/ebs_mem_model.sv
`timescale 1ns/1ps
module ebs_mem_model (
  input wire logic clk,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic alt_rd_n,
  input wire logic alt_sel,
  input wire logic [7:0] lo_main,
  input wire logic [7:0] hi_main,
  input wire logic [7:0] lo_alt,
  input wire logic [7:0] hi_alt,
  output logic [15:0] addr,
  output int ale_cnt,
  output int rd_cnt,
  output int alt_cnt
);
  logic ale_q;
  logic rd_q;
  logic alt_q;
  initial begin
    {ale_q, rd_q, alt_q} = 3'h7;
    addr = 16'h0000;
    ale_cnt = 0;
    rd_cnt = 0;
    alt_cnt = 0;
  end
  // Latch follows the bus while the strobe is high, as a transparent latch would
  always @(posedge clk) begin
    ale_q <= ale;
    rd_q <= rd_n;
    alt_q <= alt_rd_n;
    if (ale) begin
      addr <= alt_sel ? {hi_alt, lo_alt} : {hi_main, lo_main};
    end
    if (ale && !ale_q) ale_cnt <= ale_cnt + 1;
    if (!rd_n && rd_q) rd_cnt <= rd_cnt + 1;
    if (!alt_rd_n && alt_q) alt_cnt <= alt_cnt + 1;
  end
endmodule // ebs_mem_model

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import ebs_pkg::*;
  logic CORE_CLK = 0, SYS_RST = 1, RESET_N_PIN = 1, EXTERNAL_FETCH_SELECT_N = 0;
  logic ALTERNATE_BUS_SELECT = 0, VERIFY_MODE = 0, FETCH_REQ = 0, DATA_ACCESS = 0;
  logic IDLE_REQ = 0, IRQ_PENDING = 0, SER_TX_ACTIVE = 1;
  logic [15:0] FETCH_ADDR = 16'h0000;
  logic [7:0] P0_LATCH = 8'hff, P2_LATCH = 8'hff, P4_LATCH = 8'hff;
  logic [7:0] P5_LATCH = 8'hff, P6_LATCH = 8'hff, P4_IN = 8'h00;
  logic ADDRESS_LATCH_STROBE, PROGRAM_READ_STROBE_N, ALTERNATE_PROGRAM_READ_STROBE_N;
  logic [7:0] P0_OUT, P0_OE_N, P2_OUT, P2_STRONG, P4_OUT, P4_OE_N, P5_OUT, P5_OE_N;
  logic [7:0] P5_STRONG, P6_OUT, P6_STRONG, VERIFY_ADDR_LO;
  logic CPU_RUN, DMA_RUN, SER_TX_ENABLE, IN_RESET;
  logic [15:0] m_addr;
  int m_ale, m_rd, m_alt, a0, r0, e0, errors = 0, n_compared = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  ebs_bus u_dut (.CORE_CLK, .SYS_RST, .RESET_N_PIN, .EXTERNAL_FETCH_SELECT_N,
    .ALTERNATE_BUS_SELECT, .VERIFY_MODE, .FETCH_REQ, .FETCH_ADDR, .DATA_ACCESS,
    .IDLE_REQ, .IRQ_PENDING, .SER_TX_ACTIVE, .P0_LATCH, .P2_LATCH, .P4_LATCH,
    .P5_LATCH, .P6_LATCH, .P4_IN, .ADDRESS_LATCH_STROBE, .PROGRAM_READ_STROBE_N,
    .ALTERNATE_PROGRAM_READ_STROBE_N, .P0_OUT, .P0_OE_N, .P2_OUT, .P2_STRONG,
    .P4_OUT, .P4_OE_N, .P5_OUT, .P5_OE_N, .P5_STRONG, .P6_OUT, .P6_STRONG,
    .VERIFY_ADDR_LO, .CPU_RUN, .DMA_RUN, .SER_TX_ENABLE, .IN_RESET);
  ebs_mem_model u_mem (.clk(CORE_CLK), .ale(ADDRESS_LATCH_STROBE),
    .rd_n(PROGRAM_READ_STROBE_N), .alt_rd_n(ALTERNATE_PROGRAM_READ_STROBE_N),
    .alt_sel(ALTERNATE_BUS_SELECT), .lo_main(P0_OUT), .hi_main(P2_OUT),
    .lo_alt(P5_OUT), .hi_alt(P6_OUT), .addr(m_addr), .ale_cnt(m_ale),
    .rd_cnt(m_rd), .alt_cnt(m_alt));
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task automatic wait_rst(input logic v);
    int i;
    for (i = 0; i < 200 && IN_RESET !== v; i++) cyc(1);
    if (IN_RESET !== v) begin
      $display("MISMATCH IN_RESET wait expected %b seen %b", v, IN_RESET);
      errors++;
      results();
    end
  endtask
  task automatic snap();
    a0 = m_ale;
    r0 = m_rd;
    e0 = m_alt;
  endtask
  // Strobe edges are 6 clocks apart, so a 96-clock window with no skipped strobe holds exactly 16
  task automatic counts(input int ale, input int rd, input int alt);
    check("ale pulses", 16'(ale), 16'(m_ale - a0));
    check("read strobes", 16'(rd), 16'(m_rd - r0));
    check("alt read strobes", 16'(alt), 16'(m_alt - e0));
  endtask
  task automatic t_fetch();
    FETCH_REQ = 1;
    FETCH_ADDR = 16'h0123;
    cyc(48);
    snap();
    cyc(96);
    counts(16, 16, 0);
    check("latched main address", 16'h0123, m_addr);
    check("p5 strong unused", 16'h0000, 16'(P5_STRONG));
    ALTERNATE_BUS_SELECT = 1;
    FETCH_ADDR = 16'h2345;
    cyc(48);
    snap();
    cyc(96);
    counts(16, 0, 16);
    check("latched address", 16'h2345, m_addr);
    check("p5 strong", 16'h00ff, 16'(P5_STRONG));
    check("p6 strong", 16'h00ff, 16'(P6_STRONG));
    check("p0 weak ones", 16'h00ff, 16'(P0_OE_N));
    ALTERNATE_BUS_SELECT = 0;
    cyc(48);
    $display("test fetch done");
  endtask
  task automatic t_skip();
    snap();
    DATA_ACCESS = 1;
    cyc(12);
    DATA_ACCESS = 0;
    cyc(84);
    counts(15, 14, 0);
    $display("test skip done");
  endtask
  task automatic t_internal();
    EXTERNAL_FETCH_SELECT_N = 1;
    FETCH_ADDR = 16'h0100;
    cyc(48);
    snap();
    cyc(96);
    counts(16, 0, 0);
    FETCH_ADDR = 16'h1100;
    cyc(48);
    snap();
    cyc(96);
    counts(16, 16, 0);
    EXTERNAL_FETCH_SELECT_N = 0;
    $display("test internal done");
  endtask
  task automatic t_idle();
    IDLE_REQ = 1;
    cyc(1);
    IDLE_REQ = 0;
    cyc(30);
    check("cpu run", 16'h0000, 16'(CPU_RUN));
    check("dma run", 16'h0000, 16'(DMA_RUN));
    check("ale in idle", 16'h0001, 16'(ADDRESS_LATCH_STROBE));
    IRQ_PENDING = 1;
    cyc(4);
    IRQ_PENDING = 0;
    check("cpu run", 16'h0001, 16'(CPU_RUN));
    $display("test idle done");
  endtask
  task automatic t_pin_reset();
    RESET_N_PIN = 0;
    cyc(20);
    RESET_N_PIN = 1;
    cyc(3);
    check("short pulse", 16'h0000, 16'(IN_RESET));
    cyc(97);
    IDLE_REQ = 1;
    cyc(1);
    IDLE_REQ = 0;
    RESET_N_PIN = 0;
    wait_rst(1'b1);
    check("serial stopped", 16'h0000, 16'(SER_TX_ENABLE));
    cyc(30);
    check("ale in reset", 16'h0001, 16'(ADDRESS_LATCH_STROBE));
    check("read in reset", 16'h0001, 16'(PROGRAM_READ_STROBE_N));
    RESET_N_PIN = 1;
    wait_rst(1'b0);
    cyc(2);
    check("cpu after reset", 16'h0001, 16'(CPU_RUN));
    check("serial after reset", 16'h0001, 16'(SER_TX_ENABLE));
    $display("test pin reset done");
  endtask
  task automatic t_ports();
    VERIFY_MODE = 1;
    P4_IN = 8'h5a;
    cyc(3);
    check("verify low address", 16'h005a, 16'(VERIFY_ADDR_LO));
    check("p4 released", 16'h00ff, 16'(P4_OE_N));
    VERIFY_MODE = 0;
    P4_LATCH = 8'ha5;
    P5_LATCH = 8'h3c;
    cyc(3);
    check("p4 weak ones", 16'h00a5, 16'(P4_OE_N));
    check("p5 weak ones", 16'h003c, 16'(P5_OE_N));
    $display("test ports done");
  endtask
  initial begin
    cyc(10);
    check("ale in reset", 16'h0001, 16'(ADDRESS_LATCH_STROBE));
    check("read in reset", 16'h0001, 16'(PROGRAM_READ_STROBE_N));
    SYS_RST = 0;
    wait_rst(1'b0);
    t_fetch();
    t_skip();
    t_internal();
    t_idle();
    t_pin_reset();
    t_ports();
    results();
  end
  // A hang anywhere ends the run with a failure
  initial begin
    cyc(20000);
    errors++;
    results();
  end
endmodule // tb
